/* rtl/dds_word_decode_and_output_ctrl.v */
// word decoder, oscillator core and output control of the synthesizer
//
// Overview of operation
// - top two bits pick control, tuning, offset
// - half-word mode updates one 14-bit half
// - half select: 1 upper, 0 lower
// - offset word: bit 13 picks register
// - reset clears accumulator and sets output to midscale, registers kept
// - waveform appears eight cycles after release
// - pin control select picks reset source
// - reset pin asserts at once, release sampled
// - sleep pin powers down converter only
// - halt and power-down bits act independently
// - halted clock freezes accumulator and converter
// - words still accepted while clock halted
// - sleep pin asserts at once, release sampled
// - square output enable, msb or halved
// - comparator route needs no-halve bit set
// - mode bit: sine approximation or triangle
// - whole-word mode: lower first, upper second
// - select pins or bits pick active registers
`include "dds_defines.vh"
module dds_word_decode_and_output_ctrl
(
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        reset_i,
  // avalon-mm slave
  input  wire [2:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // serial link
  input  wire        serial_clk_i,
  input  wire        frame_sync_i,
  input  wire        serial_in_i,
  // device pins
  input  wire        reset_pin_i,
  input  wire        sleep_pin_i,
  input  wire        tuning_select_pin_i,
  input  wire        offset_select_pin_i,
  input  wire        comparator_i,
  // outputs
  output wire [9:0]  dac_data_o,
  output wire        dac_powerdown_o,
  output wire        square_out_o,
  output wire        square_oe_n_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [1:0] sclk_s_q;
  reg [1:0] fs_s_q;
  reg [1:0] sd_s_q;
  reg [1:0] tsel_s_q;
  reg [1:0] osel_s_q;
  reg [1:0] cmp_s_q;
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sclk_s_q <= 2'b00;
      fs_s_q   <= 2'b11;
      sd_s_q   <= 2'b00;
      tsel_s_q <= 2'b00;
      osel_s_q <= 2'b00;
      cmp_s_q  <= 2'b00;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[0], serial_clk_i};
      fs_s_q   <= {fs_s_q[0], frame_sync_i};
      sd_s_q   <= {sd_s_q[0], serial_in_i};
      tsel_s_q <= {tsel_s_q[0], tuning_select_pin_i};
      osel_s_q <= {osel_s_q[0], offset_select_pin_i};
      cmp_s_q  <= {cmp_s_q[0], comparator_i};
    end
  end

  // assert at once, release on falling clock edge
  reg [1:0] rst_pin_q;
  reg [1:0] slp_pin_q;
  always @(negedge sys_clk_i or posedge reset_pin_i)
  begin
    if (reset_pin_i)
      rst_pin_q <= 2'b11;
    else
      rst_pin_q <= {rst_pin_q[0], 1'b0};
  end
  always @(negedge sys_clk_i or posedge sleep_pin_i)
  begin
    if (sleep_pin_i)
      slp_pin_q <= 2'b11;
    else
      slp_pin_q <= {slp_pin_q[0], 1'b0};
  end

  // ----------------------------------------
  // serial receiver
  // ----------------------------------------
  // bus handshake state, read by the receiver too
  reg        wait_q;
  wire       bus_wr = avs_write_i & ~wait_q & (avs_address_i == `OFS_WORD);
  reg        sclk_d1_q;
  reg [15:0] shift_q;
  reg [4:0]  bits_q;
  reg [15:0] ser_word_q;
  reg        ser_vld_q;
  wire       sclk_fall = sclk_d1_q & ~sclk_s_q[1];
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sclk_d1_q  <= 1'b0;
      shift_q    <= 16'h0000;
      bits_q     <= 5'h00;
      ser_word_q <= 16'h0000;
      ser_vld_q  <= 1'b0;
    end
    else
    begin
      sclk_d1_q <= sclk_s_q[1];
      // a serial word meeting a bus write waits a cycle
      if (!bus_wr)
        ser_vld_q <= 1'b0;
      if (fs_s_q[1])
        bits_q <= 5'h00;
      else if (sclk_fall && bits_q != 5'h10)
      begin
        shift_q <= {shift_q[14:0], sd_s_q[1]};
        bits_q  <= bits_q + 5'h01;
        if (bits_q == 5'h0f)
        begin
          ser_word_q <= {shift_q[14:0], sd_s_q[1]};
          ser_vld_q  <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // avalon slave
  // ----------------------------------------
  reg [31:0] rdata_q;
  wire       req    = avs_read_i | avs_write_i;
  // no new request while a serial word is pending
  wire       accept = req & wait_q & ~ser_vld_q;

  // ----------------------------------------
  // word decoder and registers
  // ----------------------------------------
  reg [13:0] ctrl_q;
  reg [27:0] tune_a_q;
  reg [27:0] tune_b_q;
  reg [11:0] ofs_a_q;
  reg [11:0] ofs_b_q;
  reg        upper_a_q;
  reg        upper_b_q;
  reg [1:0]  route_q;
  wire        wvld = ser_vld_q | bus_wr;
  // bus write first; a colliding serial word follows next cycle
  wire [15:0] word = bus_wr ? avs_writedata_i[15:0] : ser_word_q;
  wire        full_mode = ctrl_q[`CB_FULL_WORD];
  wire        hi_half   = full_mode ? 1'b0 : ctrl_q[`CB_HALF_SEL];
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_q    <= `CTRL_RESET;
      tune_a_q  <= 28'h0000000;
      tune_b_q  <= 28'h0000000;
      ofs_a_q   <= 12'h000;
      ofs_b_q   <= 12'h000;
      upper_a_q <= 1'b0;
      upper_b_q <= 1'b0;
      route_q   <= `ROUTE_MSB_HALF;
    end
    else if (wvld)
    begin
      case (word[15:14])
        `TGT_CTRL:
        begin
          ctrl_q    <= word[13:0];
          upper_a_q <= 1'b0;
          upper_b_q <= 1'b0;
          // reserved routing combinations keep the last one
          if (!word[`CB_CMP_ROUTE])
            route_q <= word[`CB_NO_HALVE] ? `ROUTE_MSB : `ROUTE_MSB_HALF;
          else if (word[`CB_NO_HALVE])
            route_q <= `ROUTE_CMP;
        end
        `TGT_TUNE_A:
        begin
          if (full_mode ? upper_a_q : hi_half)
            tune_a_q[27:14] <= word[13:0];
          else
            tune_a_q[13:0]  <= word[13:0];
          upper_a_q <= full_mode & ~upper_a_q;
        end
        `TGT_TUNE_B:
        begin
          if (full_mode ? upper_b_q : hi_half)
            tune_b_q[27:14] <= word[13:0];
          else
            tune_b_q[13:0]  <= word[13:0];
          upper_b_q <= full_mode & ~upper_b_q;
        end
        default:
        begin
          if (word[`PB_OFS_SEL])
            ofs_b_q <= word[11:0];
          else
            ofs_a_q <= word[11:0];
        end
      endcase
    end
  end

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  // pins or control bits, as pin control selects; halt is off under pin control
  wire pin_ctrl  = ctrl_q[`CB_PIN_CTRL];
  wire core_rst  = pin_ctrl ? rst_pin_q[1] : ctrl_q[`CB_RESET];
  wire conv_pd   = pin_ctrl ? slp_pin_q[1] : ctrl_q[`CB_CONV_PD];
  wire halt      = ~pin_ctrl & ctrl_q[`CB_CLK_HALT];
  wire tsel      = pin_ctrl ? tsel_s_q[1] : ctrl_q[`CB_TUNE_SEL];
  wire osel      = pin_ctrl ? osel_s_q[1] : ctrl_q[`CB_OFS_SEL];
  wire [27:0] tune_sel = tsel ? tune_b_q : tune_a_q;
  wire [11:0] ofs_sel  = osel ? ofs_b_q : ofs_a_q;

  // ----------------------------------------
  // oscillator core
  // ----------------------------------------
  reg [27:0] acc_q;
  reg [2:0]  start_q;
  reg [9:0]  dac_q;
  reg        pd_q;
  reg        msb_d_q;
  reg        half_q;
  reg        sq_q;
  reg        oe_n_q;
  // phase sum wraps at one full turn
  wire [11:0] phase = acc_q[27:16] + ofs_sel;
  wire [9:0]  x     = phase[10:1];
  wire [9:0]  xn    = 10'h3ff - x;
  wire [19:0] prod  = x * xn;
  wire [8:0]  amp   = prod[18:10];
  wire [9:0]  sine  = phase[11] ? (`MIDSCALE - {1'b0, amp}) : (`MIDSCALE + {1'b0, amp});
  // linear triangle bypasses the sine approximation
  wire [9:0]  tri_w = phase[11] ? ~x : x;
  wire [9:0]  wave  = ctrl_q[`CB_TRIANGLE] ? tri_w : sine;
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      acc_q   <= 28'h0000000;
      start_q <= `STARTUP_CYCLES;
      dac_q   <= `MIDSCALE;
      pd_q    <= 1'b1;
      msb_d_q <= 1'b0;
      half_q  <= 1'b0;
      sq_q    <= 1'b0;
      oe_n_q  <= 1'b1;
    end
    else
    begin
      pd_q <= conv_pd;
      if (core_rst)
      begin
        acc_q   <= 28'h0000000;
        start_q <= `STARTUP_CYCLES;
        dac_q   <= `MIDSCALE;
        half_q  <= 1'b0;
        msb_d_q <= 1'b0;
      end
      else if (!halt)
      begin
        // startup hold after a core reset
        if (start_q != 3'd0)
          start_q <= start_q - 3'd1;
        else
        begin
          acc_q <= acc_q + tune_sel;
          dac_q <= wave;
        end
        msb_d_q <= dac_q[9];
        if (dac_q[9] && !msb_d_q)
          half_q <= ~half_q;
      end
      oe_n_q <= ~ctrl_q[`CB_OUT_EN];
      case (route_q)
        `ROUTE_MSB: sq_q <= dac_q[9];
        `ROUTE_CMP: sq_q <= cmp_s_q[1];
        default:    sq_q <= half_q;
      endcase
    end
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  always @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q <= ~accept;
      if (accept)
      begin
        case (avs_address_i)
          `OFS_WORD:   rdata_q <= {18'h00000, ctrl_q};
          `OFS_STATUS: rdata_q <= {25'h0000000, start_q == 3'd0, halt, pd_q, core_rst, osel, tsel, pin_ctrl};
          `OFS_TUNE_A: rdata_q <= {4'h0, tune_a_q};
          `OFS_TUNE_B: rdata_q <= {4'h0, tune_b_q};
          `OFS_OFFSET: rdata_q <= {4'h0, ofs_b_q, 4'h0, ofs_a_q};
          `OFS_PHASE:  rdata_q <= {20'h00000, phase};
          default:     rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // output drivers
  // ----------------------------------------
  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign dac_data_o        = dac_q;
  assign dac_powerdown_o   = pd_q;
  assign square_out_o      = sq_q;
  assign square_oe_n_o     = oe_n_q;

endmodule

/* rtl/dds_defines.vh */
// constants of the synthesizer word decoder and output control
`ifndef DDS_DEFINES_VH
`define DDS_DEFINES_VH
// bus word offsets (word addresses)
`define OFS_WORD       3'd0
`define OFS_STATUS     3'd1
`define OFS_TUNE_A     3'd2
`define OFS_TUNE_B     3'd3
`define OFS_OFFSET     3'd4
`define OFS_PHASE      3'd5
// word target codes, bits 15:14
`define TGT_CTRL       2'b00
`define TGT_TUNE_A     2'b01
`define TGT_TUNE_B     2'b10
`define TGT_OFFSET     2'b11
// control word fields
`define CB_FULL_WORD   13
`define CB_HALF_SEL    12
`define CB_TUNE_SEL    11
`define CB_OFS_SEL     10
`define CB_PIN_CTRL    9
`define CB_RESET       8
`define CB_CLK_HALT    7
`define CB_CONV_PD     6
`define CB_OUT_EN      5
`define CB_CMP_ROUTE   4
`define CB_NO_HALVE    3
`define CB_TRIANGLE    1
// phase offset word fields
`define PB_OFS_SEL     13
// reset values and square route codes
`define CTRL_RESET     14'h0000
`define ROUTE_MSB_HALF 2'b00
`define ROUTE_MSB      2'b01
`define ROUTE_CMP      2'b10
// hold cycles after reset release; the waveform follows one cycle later
`define STARTUP_CYCLES 3'd7
`define MIDSCALE       10'h200
`endif

/* test/dds_ctrl_asserts.sv */
// checker of the synthesizer control block
module dds_ctrl_asserts (
  // watched ports
  input wire        sys_clk_i,
  input wire        reset_i,
  input wire [2:0]  avs_address_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire        avs_waitrequest_o,
  input wire        reset_pin_i,
  input wire        sleep_pin_i,
  input wire [9:0]  dac_data_o,
  input wire        dac_powerdown_o,
  input wire        square_oe_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // control word as written over the bus
  logic [13:0] ctl_q;
  wire         pin_c = ctl_q[9];
  always_ff @(posedge sys_clk_i or posedge reset_i)
    if (reset_i)
      ctl_q <= 14'h0000;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 3'h0 && avs_writedata_i[15:14] == 2'h0)
      ctl_q <= avs_writedata_i[13:0];
  sequence s_rel; pin_c && $fell(reset_pin_i); endsequence
  sequence s_pd; (!pin_c && ctl_q[6])[*3]; endsequence
  sequence s_on; (!pin_c && !ctl_q[6])[*3]; endsequence
  property p_stand; $fell(avs_waitrequest_o) |=> avs_waitrequest_o; endproperty
  property p_pin_rst; pin_c && reset_pin_i |=> dac_data_o == 10'h200; endproperty
  property p_release; s_rel |-> (dac_data_o == 10'h200)[*8]; endproperty
  property p_sleep; pin_c && sleep_pin_i |=> dac_powerdown_o; endproperty
  property p_pd_bit; s_pd |-> dac_powerdown_o; endproperty
  property p_pd_off; s_on |-> !dac_powerdown_o; endproperty
  property p_halt; (!pin_c && ctl_q[7])[*3] |-> $stable(dac_data_o); endproperty
  property p_oe; $stable(ctl_q)[*3] |-> square_oe_n_o == !ctl_q[5]; endproperty
  a_stand: assert property (p_stand) else $error("waitrequest low too long");
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset not at once");
  a_release: assert property (p_release) else $error("startup hold short");
  a_sleep: assert property (p_sleep) else $error("sleep pin ignored");
  a_pd_bit: assert property (p_pd_bit) else $error("powerdown bit ignored");
  a_pd_off: assert property (p_pd_off) else $error("powerdown wrongly set");
  a_halt: assert property (p_halt) else $error("halted output moved");
  a_oe: assert property (p_oe) else $error("enable mismatch");
endmodule
bind dds_word_decode_and_output_ctrl dds_ctrl_asserts u_chk (
  .sys_clk_i         (sys_clk_i),
  .reset_i           (reset_i),
  .avs_address_i     (avs_address_i),
  .avs_write_i       (avs_write_i),
  .avs_writedata_i   (avs_writedata_i),
  .avs_waitrequest_o (avs_waitrequest_o),
  .reset_pin_i       (reset_pin_i),
  .sleep_pin_i       (sleep_pin_i),
  .dac_data_o        (dac_data_o),
  .dac_powerdown_o   (dac_powerdown_o),
  .square_oe_n_o     (square_oe_n_o)
);

/* test/serial_host.sv */
// host model writing words over the serial link
module serial_host (
  // link pins
  output logic serial_clk_o = 1'b1,
  output logic frame_sync_o = 1'b1,
  output logic serial_in_o  = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock idles high; released data line shows the inverse
  task automatic send_word(input logic [15:0] w);
    // step off the system clock edge
    #0.25;
    frame_sync_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      serial_in_o = w[i];
      #62.5 serial_clk_o = 1'b0;
      #62.5 serial_clk_o = 1'b1;
    end
    #62.5 frame_sync_o = 1'b1;
    serial_in_o = ~serial_in_o;
  endtask
endmodule

/* test/tb_top.sv */
// self-checking bench of the synthesizer control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic        rst_pin = 1'b0, sleep_pin = 1'b0, tsel = 1'b0, osel = 1'b0, cmp = 1'b0;
  logic        wait_req, sclk, frame_sync, serial_in, pd, sq, oe_n;
  logic [9:0]  dac, snap;
  int          n_errors = 0, checked = 0;
  always #4 sys_clk = ~sys_clk;
  serial_host u_host (.serial_clk_o(sclk), .frame_sync_o(frame_sync), .serial_in_o(serial_in));
  dds_word_decode_and_output_ctrl u_dut (
    .sys_clk_i(sys_clk), .reset_i(rst), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .serial_clk_i(sclk), .frame_sync_i(frame_sync),
    .serial_in_i(serial_in), .reset_pin_i(rst_pin), .sleep_pin_i(sleep_pin),
    .tuning_select_pin_i(tsel), .offset_select_pin_i(osel), .comparator_i(cmp),
    .dac_data_o(dac), .dac_powerdown_o(pd), .square_out_o(sq), .square_oe_n_o(oe_n)
  );
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wait_req !== 1'b0 && n < 40);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    chk("answer", 32'h0, {31'h0, wait_req});
  endtask
  task automatic ctl(input logic [15:0] d);
    bus(1'b1, 3'h0, {16'h0, d});
  endtask
  task automatic rchk(input logic [2:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, got);
  endtask
  task automatic moving;
    snap = dac;
    tick(1);
    chk("dac moving", 32'h1, {31'h0, dac !== snap});
  endtask
  task automatic t_words;
    chk("oe idle", 32'h1, {31'h0, oe_n});
    rchk(3'h7, 32'h0, "unmapped");
    ctl(16'h2000);
    ctl(16'h4abc);
    ctl(16'h7234);
    rchk(3'h2, {4'h0, 14'h3234, 14'h0abc}, "tune a");
    ctl(16'h1000);
    ctl(16'h8055);
    rchk(3'h3, {4'h0, 14'h0055, 14'h0000}, "tune b hi");
    ctl(16'h0000);
    ctl(16'hbfff);
    rchk(3'h3, {4'h0, 14'h0055, 14'h3fff}, "tune b lo");
    ctl(16'hd123);
    ctl(16'he456);
    rchk(3'h4, {4'h0, 12'h456, 4'h0, 12'h123}, "offsets");
    u_host.send_word(16'hc7ff);
    tick(10);
    rchk(3'h4, {4'h0, 12'h456, 4'h0, 12'h7ff}, "serial offset");
  endtask
  task automatic t_reset;
    ctl(16'h2200);
    tick(12);
    moving();
    rst_pin <= 1'b1;
    tick(3);
    chk("pin reset", 32'h200, {22'h0, dac});
    rst_pin <= 1'b0;
    tick(8);
    chk("hold", 32'h200, {22'h0, dac});
    tick(6);
    moving();
    rchk(3'h2, {4'h0, 14'h3234, 14'h0abc}, "kept");
    ctl(16'h2300);
    tick(12);
    moving();
    ctl(16'h2100);
    tick(3);
    chk("bit reset", 32'h200, {22'h0, dac});
  endtask
  task automatic t_sleep;
    ctl(16'h2200);
    sleep_pin <= 1'b1;
    tick(12);
    chk("pd pin", 32'h1, {31'h0, pd});
    moving();
    ctl(16'h0080);
    tick(4);
    chk("pd off", 32'h0, {31'h0, pd});
    snap = dac;
    ctl(16'h4001);
    chk("halted", {22'h0, snap}, {22'h0, dac});
    rchk(3'h2, {4'h0, 14'h3234, 14'h0001}, "halt write");
    ctl(16'h00c0);
    tick(4);
    chk("pd both", 32'h1, {31'h0, pd});
    ctl(16'h0000);
    sleep_pin <= 1'b0;
    tick(12);
    moving();
  endtask
  task automatic t_out;
    ctl(16'h0200);
    tsel <= 1'b1;
    osel <= 1'b1;
    tick(4);
    rchk(3'h1, 32'h47, "pin select");
    tsel <= 1'b0;
    osel <= 1'b0;
    ctl(16'h0c00);
    tick(4);
    rchk(3'h1, 32'h46, "bit select");
    ctl(16'h0038);
    cmp <= 1'b1;
    tick(6);
    chk("cmp high", 32'h1, {31'h0, sq});
    ctl(16'h0030);
    cmp <= 1'b0;
    tick(6);
    chk("cmp kept", 32'h0, {31'h0, sq});
    ctl(16'h0020);
    tick(3);
    chk("oe on", 32'h0, {31'h0, oe_n});
    ctl(16'h0028);
    tick(3);
    snap = dac;
    tick(1);
    chk("msb out", {31'h0, snap[9]}, {31'h0, sq});
  endtask
  task automatic t_wave;
    ctl(16'h2102);
    ctl(16'h4000);
    ctl(16'h4000);
    ctl(16'hc100);
    ctl(16'h2002);
    tick(12);
    chk("triangle", 32'h80, {22'h0, dac});
    ctl(16'hc000);
    ctl(16'h2000);
    tick(4);
    chk("sine zero", 32'h200, {22'h0, dac});
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    tick(10);
    rst <= 1'b0;
    t_words();
    t_reset();
    t_sleep();
    t_out();
    t_wave();
    tally_and_finish();
  end
  initial
  begin
    #100us;
    n_errors++;
    tally_and_finish();
  end
endmodule
